// *** core/tmr16_pkg.sv ***
// Purpose: Shared constants, types and register map of the 16-bit interval timer.
// Assumes: Classic Wishbone, 32-bit data, byte addresses on a 16-bit address bus.
// Notes:   Control, count, period and enable registers have plain, clear, set and invert word aliases.
package tmr16_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned ADR_W = 16;
   localparam int unsigned DAT_W = 32;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PS_W  = 8;
   localparam int unsigned STS_W = 2;
   localparam int unsigned NPIN  = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Register base addresses (control, count, period, enable aliases at +0x4 clear, +0x8 set, +0xC invert)
   localparam logic [ADR_W-1:0] OFF_CONTROL = 16'h8000;
   localparam logic [ADR_W-1:0] OFF_COUNT   = 16'h8010;
   localparam logic [ADR_W-1:0] OFF_PERIOD  = 16'h8020;
   localparam logic [ADR_W-1:0] OFF_STATUS  = 16'h8030;
   localparam logic [ADR_W-1:0] OFF_INTCLR  = 16'h8040;
   localparam logic [ADR_W-1:0] OFF_INTEN   = 16'h8050;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [CNT_W-1:0] RST_CONTROL   = 16'h0000;
   localparam logic [CNT_W-1:0] RST_COUNT     = 16'h0000;
   localparam logic [CNT_W-1:0] RST_PERIOD    = 16'hFFFF;
   localparam logic [CNT_W-1:0] CTL_WR_MASK   = 16'hB3B6;
   localparam logic [CNT_W-1:0] ZERO_HALF     = 16'h0000;
   localparam logic [STS_W-1:0] STS_ZERO      = 2'h0;
   localparam int unsigned      STS_MATCH_BIT = 0;
   localparam int unsigned      STS_GATE_BIT  = 1;
   localparam int unsigned      PIN_SEC_OSC   = 0;
   localparam int unsigned      PIN_TIN       = 1;
   localparam int unsigned      PIN_LP_RC     = 2;
   localparam int unsigned      PIN_GATE      = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Prescale terminal counts
   localparam logic [PS_W-1:0] PS_MAX_1   = 8'h00;
   localparam logic [PS_W-1:0] PS_MAX_8   = 8'h07;
   localparam logic [PS_W-1:0] PS_MAX_64  = 8'h3F;
   localparam logic [PS_W-1:0] PS_MAX_256 = 8'hFF;

   ////////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {
      AL_WRITE  = 2'b00,
      AL_CLEAR  = 2'b01,
      AL_SET    = 2'b10,
      AL_INVERT = 2'b11
   } tmr16_alias_e;

   typedef enum logic [1:0] {
      PS_DIV1   = 2'b00,
      PS_DIV8   = 2'b01,
      PS_DIV64  = 2'b10,
      PS_DIV256 = 2'b11
   } tmr16_prescale_e;

   typedef enum logic [1:0] {
      EXT_SEC_OSC = 2'b00,
      EXT_TIN     = 2'b01,
      EXT_LP_RC   = 2'b10,
      EXT_RSVD    = 2'b11
   } tmr16_ext_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Control register layout
   typedef struct packed {
      logic            on;
      logic            rsv14;
      logic            idle_stop;
      logic            async_write_protect;
      logic            async_write_pending;
      logic            rsv10;
      tmr16_ext_e      external_clock_source;
      logic            gate_enable;
      logic            rsv6;
      tmr16_prescale_e prescale_select;
      logic            rsv3;
      logic            external_sync_select;
      logic            clock_source_select;
      logic            rsv0;
   } tmr16_ctl_s;

endpackage // tmr16_pkg

// *** core/tmr16_core.sv ***
// Purpose: 16-bit interval timer / event counter with period match, gate and prescaler.
// Assumes: Single clock clk_i; idle_i and sleep_i come from logic on clk_i.
// Notes:   External clock pins and gate pass a three-flop synchroniser.

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 16-bit counter, internal or external, sync or async
// - Four modes: internal, gated, sync external, async
// - Async external counting continues through sleep
// - Bit 15 starts and stops the timer
// - Idle-stop bit halts counting during idle
// - Protected async writes ignored while one pending
// - Unprotected async writes replace the pending value
// - Pending flag high while async write crosses
// - Pending flag reads zero in synchronous mode
// - External source: oscillator, pin, RC, reserved
// - Source select: internal clock or external source
// - Gate bit used only with internal clock
// - Prescale 1:1, 1:8, 1:64, 1:256
// - Sync bit used only with external clock
// - Clear, set, invert aliases at +4, +8, +C
// - Unimplemented bits ignore writes, read zero
module tmr16_core (
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          ce_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [tmr16_pkg::ADR_W-1:0]   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [tmr16_pkg::DAT_W-1:0]   wb_dat_i,
   output logic      [tmr16_pkg::DAT_W-1:0]   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          secondary_osc_i,
   input  wire logic                          timer_input_pin_i,
   input  wire logic                          low_power_rc_osc_i,
   input  wire logic                          gate_i,
   input  wire logic                          idle_i,
   input  wire logic                          sleep_i,
   output logic                               irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [tmr16_pkg::CNT_W-1:0]  ctl_q;
   logic [tmr16_pkg::CNT_W-1:0]  count_q;
   logic [tmr16_pkg::CNT_W-1:0]  hold_q;
   logic [tmr16_pkg::CNT_W-1:0]  period_q;
   logic                         pending_q;
   logic [tmr16_pkg::PS_W-1:0]   ps_q;
   logic [tmr16_pkg::STS_W-1:0]  sts_q;
   logic [tmr16_pkg::STS_W-1:0]  ien_q;
   logic                         ack_q;
   logic [tmr16_pkg::DAT_W-1:0]  rdat_q;
   logic                         irq_q;
   logic [tmr16_pkg::NPIN-1:0]   pin_raw;
   logic [tmr16_pkg::NPIN-1:0]   s1_q;
   logic [tmr16_pkg::NPIN-1:0]   s2_q;
   logic [tmr16_pkg::NPIN-1:0]   s3_q;
   logic [tmr16_pkg::NPIN-1:0]   lvl_q;
   logic [tmr16_pkg::NPIN-1:0]   prev_q;
   tmr16_pkg::tmr16_ctl_s        ctl;
   tmr16_pkg::tmr16_alias_e      op;
   logic [tmr16_pkg::ADR_W-1:0]  base;
   logic [tmr16_pkg::DAT_W-1:0]  wmask;
   logic                         bus_req;
   logic                         wr_en;
   logic [tmr16_pkg::CNT_W-1:0]  ctl_new;
   logic [tmr16_pkg::CNT_W-1:0]  cnt_new;
   logic [tmr16_pkg::CNT_W-1:0]  per_new;
   logic [tmr16_pkg::STS_W-1:0]  ien_new;
   logic [tmr16_pkg::STS_W-1:0]  sts_set;
   logic [tmr16_pkg::STS_W-1:0]  sts_clr;
   logic                         ext_lvl;
   logic                         ext_prev;
   logic                         ext_rise;
   logic                         gate_fall;
   logic                         async_mode;
   logic                         gated;
   logic                         run;
   logic                         src_tick;
   logic [tmr16_pkg::PS_W-1:0]   ps_max;
   logic                         tick;
   logic                         cnt_wr;
   logic                         sync_wr;
   logic                         async_take;
   logic                         commit;
   logic                         match;
   logic [tmr16_pkg::DAT_W-1:0]  ctl_wide;
   logic [tmr16_pkg::DAT_W-1:0]  cnt_wide;
   logic [tmr16_pkg::DAT_W-1:0]  per_wide;
   logic [tmr16_pkg::DAT_W-1:0]  ien_wide;

   ////////////////////////////////////////////////////////////////////////////////
   // Alias write function
   function automatic logic [tmr16_pkg::DAT_W-1:0] alias_f(
      input logic [tmr16_pkg::DAT_W-1:0] old,
      input logic [tmr16_pkg::DAT_W-1:0] wd,
      input logic [tmr16_pkg::DAT_W-1:0] m,
      input tmr16_pkg::tmr16_alias_e     o
   );
      logic [tmr16_pkg::DAT_W-1:0] r;
      r = old;
      case (o)
         tmr16_pkg::AL_WRITE:  r = (old & ~m) | (wd & m);
         tmr16_pkg::AL_CLEAR:  r = old & ~(wd & m);
         tmr16_pkg::AL_SET:    r = old | (wd & m);
         tmr16_pkg::AL_INVERT: r = old ^ (wd & m);
         default:              r = old;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign ctl     = tmr16_pkg::tmr16_ctl_s'(ctl_q);
   assign op      = tmr16_pkg::tmr16_alias_e'(wb_adr_i[3:2]);
   assign base    = {wb_adr_i[tmr16_pkg::ADR_W-1:4], 4'h0};
   assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_en   = bus_req & wb_we_i;

   assign ctl_wide = alias_f({tmr16_pkg::ZERO_HALF, ctl_q}, wb_dat_i, wmask, op);
   assign cnt_wide = alias_f({tmr16_pkg::ZERO_HALF, count_q}, wb_dat_i, wmask, op);
   assign per_wide = alias_f({tmr16_pkg::ZERO_HALF, period_q}, wb_dat_i, wmask, op);
   assign ien_wide = alias_f({{(tmr16_pkg::DAT_W-tmr16_pkg::STS_W){1'b0}}, ien_q}, wb_dat_i, wmask, op);

   // Only the implemented low bits of each alias result are kept
   assign ctl_new  = ctl_wide[tmr16_pkg::CNT_W-1:0] & tmr16_pkg::CTL_WR_MASK;
   assign cnt_new  = cnt_wide[tmr16_pkg::CNT_W-1:0];
   assign per_new  = per_wide[tmr16_pkg::CNT_W-1:0];
   assign ien_new  = ien_wide[tmr16_pkg::STS_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   assign pin_raw = {gate_i, low_power_rc_osc_i, timer_input_pin_i, secondary_osc_i};

   generate
      for (genvar i = 0; i < tmr16_pkg::NPIN; i++) begin : g_sync
         always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
               s1_q[i]   <= 1'b0;
               s2_q[i]   <= 1'b0;
               s3_q[i]   <= 1'b0;
               lvl_q[i]  <= 1'b0;
               prev_q[i] <= 1'b0;
            end else if (ce_i) begin
               s1_q[i]   <= pin_raw[i];
               s2_q[i]   <= s1_q[i];
               s3_q[i]   <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  lvl_q[i] <= s3_q[i];
               end
               prev_q[i] <= lvl_q[i];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Clock source, gate and prescaler
   always_comb begin
      case (ctl.external_clock_source)
         tmr16_pkg::EXT_SEC_OSC: begin
            ext_lvl  = lvl_q[tmr16_pkg::PIN_SEC_OSC];
            ext_prev = prev_q[tmr16_pkg::PIN_SEC_OSC];
         end
         tmr16_pkg::EXT_TIN: begin
            ext_lvl  = lvl_q[tmr16_pkg::PIN_TIN];
            ext_prev = prev_q[tmr16_pkg::PIN_TIN];
         end
         tmr16_pkg::EXT_LP_RC: begin
            ext_lvl  = lvl_q[tmr16_pkg::PIN_LP_RC];
            ext_prev = prev_q[tmr16_pkg::PIN_LP_RC];
         end
         default: begin
            ext_lvl  = 1'b0;
            ext_prev = 1'b0;
         end
      endcase
   end

   always_comb begin
      case (ctl.prescale_select)
         tmr16_pkg::PS_DIV1:   ps_max = tmr16_pkg::PS_MAX_1;
         tmr16_pkg::PS_DIV8:   ps_max = tmr16_pkg::PS_MAX_8;
         tmr16_pkg::PS_DIV64:  ps_max = tmr16_pkg::PS_MAX_64;
         tmr16_pkg::PS_DIV256: ps_max = tmr16_pkg::PS_MAX_256;
         default:              ps_max = tmr16_pkg::PS_MAX_1;
      endcase
   end

   assign ext_rise   = ext_lvl & ~ext_prev;
   assign gate_fall  = prev_q[tmr16_pkg::PIN_GATE] & ~lvl_q[tmr16_pkg::PIN_GATE];
   assign async_mode = ctl.clock_source_select & ~ctl.external_sync_select;
   assign gated      = ~ctl.clock_source_select & ctl.gate_enable;
   assign run        = ctl.on
                       & ~(idle_i & ctl.idle_stop)
                       & ~(sleep_i & ~async_mode);
   assign src_tick   = ctl.clock_source_select ? ext_rise :
                       (gated ? lvl_q[tmr16_pkg::PIN_GATE] : 1'b1);
   assign tick       = run & src_tick & (ps_q == ps_max);
   assign match      = (count_q == period_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Counter write paths
   assign cnt_wr     = wr_en & (base == tmr16_pkg::OFF_COUNT);
   assign sync_wr    = cnt_wr & ~async_mode;
   assign async_take = cnt_wr & async_mode & ~(pending_q & ctl.async_write_protect);
   assign commit     = pending_q & (ext_rise | ~async_mode);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ps_q <= 8'h00;
      end else if (ce_i) begin
         if (!run || sync_wr || commit) begin
            ps_q <= 8'h00;
         end else if (src_tick) begin
            ps_q <= (ps_q == ps_max) ? 8'h00 : ps_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_q    <= tmr16_pkg::RST_COUNT;
         pending_q <= 1'b0;
      end else if (ce_i) begin
         if (async_take) begin
            hold_q    <= cnt_new;
            pending_q <= 1'b1;
         end else if (commit) begin
            pending_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_q <= tmr16_pkg::RST_COUNT;
      end else if (ce_i) begin
         if (sync_wr) begin
            count_q <= cnt_new;
         end else if (commit && !async_take) begin
            count_q <= hold_q;
         end else if (tick) begin
            count_q <= match ? tmr16_pkg::RST_COUNT : count_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control, period and interrupt enable registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctl_q <= tmr16_pkg::RST_CONTROL;
      end else if (ce_i && wr_en && base == tmr16_pkg::OFF_CONTROL) begin
         ctl_q <= ctl_new;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         period_q <= tmr16_pkg::RST_PERIOD;
      end else if (ce_i && wr_en && base == tmr16_pkg::OFF_PERIOD) begin
         period_q <= per_new;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ien_q <= tmr16_pkg::STS_ZERO;
      end else if (ce_i && wr_en && base == tmr16_pkg::OFF_INTEN) begin
         ien_q <= ien_new;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status and interrupt
   always_comb begin
      sts_set = tmr16_pkg::STS_ZERO;
      sts_set[tmr16_pkg::STS_MATCH_BIT] = tick & match;
      sts_set[tmr16_pkg::STS_GATE_BIT]  = gated & ctl.on & gate_fall;
      sts_clr = tmr16_pkg::STS_ZERO;
      if (wr_en && base == tmr16_pkg::OFF_INTCLR && op == tmr16_pkg::AL_WRITE) begin
         sts_clr = wb_dat_i[1:0] & wmask[1:0];
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sts_q <= tmr16_pkg::STS_ZERO;
         irq_q <= 1'b0;
      end else if (ce_i) begin
         sts_q <= (sts_q & ~sts_clr) | sts_set;
         irq_q <= |(sts_q & ien_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone answer and read data
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q  <= bus_req;
         rdat_q <= 32'h0000_0000;
         if (bus_req && !wb_we_i && op == tmr16_pkg::AL_WRITE) begin
            case (base)
               tmr16_pkg::OFF_CONTROL: begin
                  rdat_q[15:0] <= ctl_q;
                  rdat_q[11]   <= pending_q & async_mode;
               end
               tmr16_pkg::OFF_COUNT:  rdat_q[15:0] <= count_q;
               tmr16_pkg::OFF_PERIOD: rdat_q[15:0] <= period_q;
               tmr16_pkg::OFF_STATUS: rdat_q[1:0]  <= sts_q;
               tmr16_pkg::OFF_INTEN:  rdat_q[1:0]  <= ien_q;
               default:               rdat_q       <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq_o    = irq_q;

endmodule // tmr16_core

// *** bench/tmr16_core_asserts.sv ***
// Purpose: Port checks of the timer register bus and interrupt
// Assumes: Single clock domain, reset_i asynchronous active high
// Notes:   Bound to tmr16_core from the bench top file
module tmr16_core_asserts (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        ce_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic req;
   logic en_seen_q;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
   // Set once software has touched the enable register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) en_seen_q <= 1'b0;
      else if (req & wb_we_i & (wb_adr_i[15:4] == 12'h805)) en_seen_q <= 1'b1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   chk_ack_cause: assert property (!(wb_cyc_i & wb_stb_i) && ce_i |=> !wb_ack_o)
      else $error("ack without request");
   chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data idle");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper half set");
   chk_alias_zero: assert property (req && !wb_we_i && wb_adr_i[3:2] != 2'h0 |=> wb_dat_o == 32'h0000_0000)
      else $error("alias read data");
   chk_unmapped_zero: assert property (req && !wb_we_i &&
      !(wb_adr_i[15:8] == 8'h80 && wb_adr_i[7:4] <= 4'h5) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read data");
   chk_irq_off: assert property (req && wb_we_i && wb_adr_i == 16'h8050 && wb_sel_i[0]
      && wb_dat_i[1:0] == 2'h0 |=> ##1 !irq_o) else $error("irq after disable");
   chk_irq_quiet: assert property (!en_seen_q |-> !irq_o) else $error("irq never enabled");
   cover property (req && wb_we_i);
   cover property ($rose(irq_o));
   cover property (req && !wb_we_i && wb_adr_i == 16'h8000);
endmodule // tmr16_core_asserts

// *** bench/tmr16_core_bench.sv ***
// Purpose: Self-checking bench of the 16-bit timer
// Assumes: Pins, gate and clock enable driven by the bench
// Notes:   Counts allow slack for bus latency
module tmr16_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ON = 16'h8000, IDL = 16'h2000, PROT = 16'h1000, PEND = 16'h0800;
   localparam logic [15:0] GATE = 16'h0080, SYN = 16'h0004, EXT = 16'h0002;
   logic        clk_i, reset_i, ce, cyc, stb, we, gate, idle, sleep;
   logic [3:0]  sel;
   logic [15:0] adr;
   logic [31:0] wdat, rdat;
   logic [2:0]  ext;
   logic [31:0] dat_o;
   logic        ack, irq;
   int          num_errors, checks_done, tick;

   tmr16_core tmr16_core_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .secondary_osc_i(ext[0]), .timer_input_pin_i(ext[1]), .low_power_rc_osc_i(ext[2]),
      .gate_i(gate), .idle_i(idle), .sleep_i(sleep), .irq_o(irq));

   ////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      tick <= tick + 1;
      if (tick == 20000) begin
         num_errors++;
         close_out();
      end
   end
   task close_out;
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      chk({31'h0, got >= lo && got <= hi}, 32'h0000_0001);
   endtask
   task wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Waits for ack with no limit of its own; the cycle ceiling ends a hang
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
   task rd(input logic [15:0] a); bus(1'b0, a, 32'h0000_0000); endtask
   task run(input logic [15:0] c, input int n);
      wr(16'h8000, {16'h0000, c});
      wait_clk(n);
      wr(16'h8000, 32'h0000_0000);
   endtask
   task pulses(input logic [2:0] m, input int k);
      repeat (k) begin
         @(posedge clk_i) ext <= m;
         wait_clk(5);
         ext <= 3'h0;
         wait_clk(5);
      end
   endtask

   ////////////////////////////////////////
   task t_regs;
      rd(16'h8000);
      chk(rdat, 32'h0000_0000);
      rd(16'h8010);
      chk(rdat, 32'h0000_0000);
      rd(16'h8020);
      chk(rdat, 32'h0000_FFFF);
      wr(16'h8000, 32'hFFFF_FFFF);
      rd(16'h8000);
      chk(rdat, 32'h0000_B3B6);
      wr(16'h8004, 32'hFFFF_FFFF);
      rd(16'h8000);
      chk(rdat, 32'h0000_0000);
      wr(16'h8024, 32'h0000_00F0);
      rd(16'h8020);
      chk(rdat, 32'h0000_FF0F);
      wr(16'h8028, 32'h0000_00F0);
      rd(16'h8020);
      chk(rdat, 32'h0000_FFFF);
      wr(16'h802C, 32'h0000_FFF0);
      rd(16'h8020);
      chk(rdat, 32'h0000_000F);
      rd(16'h8028);
      chk(rdat, 32'h0000_0000);
      wr(16'h9000, 32'hFFFF_FFFF);
      rd(16'h9000);
      chk(rdat, 32'h0000_0000);
      wr(16'h8030, 32'h0000_0003);
      rd(16'h8030);
      chk(rdat, 32'h0000_0000);
   endtask
   task t_pre;
      int d;
      int e;
      logic [31:0] c;
      wr(16'h8020, 32'h0000_FFFF);
      for (int p = 0; p < 4; p++) begin
         d = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
         e = 515 / d;
         wr(16'h8010, 32'h0000_0000);
         run(ON | 16'(p << 4), 512);
         rd(16'h8010);
         c = rdat;
         rng(c, e - ((p == 0) ? 3 : 1), e + ((p == 0) ? 3 : 1));
         wait_clk(20);
         rd(16'h8010);
         chk(rdat, c);
      end
   endtask
   task t_per;
      wr(16'h8020, 32'h0000_0004);
      wr(16'h8010, 32'h0000_0000);
      wr(16'h8050, 32'h0000_0001);
      wr(16'h8000, {16'h0000, ON});
      wait_clk(30);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(16'h8000, 32'h0000_0000);
      rd(16'h8010);
      rng(rdat, 32'h0000_0000, 32'h0000_0004);
      rd(16'h8030);
      chk(rdat, 32'h0000_0001);
      wr(16'h8040, 32'h0000_0003);
      wait_clk(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(16'h8050, 32'h0000_0000);
      run(ON, 20);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(16'h8030);
      chk(rdat, 32'h0000_0001);
      wr(16'h8040, 32'h0000_0003);
   endtask
   task t_idle;
      wr(16'h8020, 32'h0000_FFFF);
      wr(16'h8010, 32'h0000_1234);
      @(posedge clk_i) idle <= 1'b1;
      run(ON | IDL, 20);
      rd(16'h8010);
      chk(rdat, 32'h0000_1234);
      @(posedge clk_i) begin
         idle <= 1'b0;
         sleep <= 1'b1;
      end
      run(ON, 20);
      rd(16'h8010);
      chk(rdat, 32'h0000_1234);
      @(posedge clk_i) begin
         idle <= 1'b1;
         sleep <= 1'b0;
      end
      run(ON, 20);
      rd(16'h8010);
      rng(rdat, 32'h0000_1247, 32'h0000_124D);
      @(posedge clk_i) idle <= 1'b0;
   endtask
   task t_ext;
      logic [2:0] m;
      for (int s = 0; s < 4; s++) begin
         m = (s < 3) ? 3'(1 << s) : 3'h0;
         wr(16'h8010, 32'h0000_0000);
         wr(16'h8000, {16'h0000, ON | EXT | SYN | GATE | 16'(s << 8)});
         pulses(~m, 3);
         pulses(m, 5);
         wr(16'h8000, 32'h0000_0000);
         rd(16'h8010);
         chk(rdat, (s < 3) ? 32'h0000_0005 : 32'h0000_0000);
      end
   endtask
   task t_async;
      logic [15:0] c;
      for (int p = 0; p < 2; p++) begin
         c = ON | EXT | 16'h0100 | ((p == 1) ? PROT : 16'h0000);
         wr(16'h8010, 32'h0000_0000);
         wr(16'h8000, {16'h0000, c});
         wr(16'h8010, 32'h0000_0100);
         rd(16'h8000);
         chk(rdat, {16'h0000, c | PEND});
         wr(16'h8010, 32'h0000_0200);
         pulses(3'h2, 1);
         rd(16'h8000);
         chk(rdat, {16'h0000, c});
         wr(16'h8000, 32'h0000_0000);
         rd(16'h8010);
         if (p == 1) rng(rdat, 32'h0000_0100, 32'h0000_0101);
         else rng(rdat, 32'h0000_0200, 32'h0000_0201);
      end
   endtask
   task t_gate;
      wr(16'h8010, 32'h0000_0000);
      wr(16'h8000, {16'h0000, ON | GATE});
      wait_clk(10);
      @(posedge clk_i) gate <= 1'b1;
      wait_clk(40);
      gate <= 1'b0;
      wait_clk(10);
      wr(16'h8000, 32'h0000_0000);
      rd(16'h8010);
      rng(rdat, 32'h0000_0026, 32'h0000_002A);
      rd(16'h8030);
      chk(rdat, 32'h0000_0002);
      wr(16'h8040, 32'h0000_0003);
   endtask
   // Counter runs two edges, freezes 50 with enable low, then two more
   task t_ce;
      wr(16'h8010, 32'h0000_0000);
      wr(16'h8000, {16'h0000, ON});
      @(posedge clk_i) ce <= 1'b0;
      wait_clk(50);
      ce <= 1'b1;
      wr(16'h8000, 32'h0000_0000);
      rd(16'h8010);
      chk(rdat, 32'h0000_0004);
   endtask

   ////////////////////////////////////////
   initial begin
      cyc         = 1'b0;
      stb         = 1'b0;
      we          = 1'b0;
      adr         = 16'h0000;
      wdat        = 32'h0000_0000;
      sel         = 4'h0;
      ext         = 3'h0;
      gate        = 1'b0;
      idle        = 1'b0;
      sleep       = 1'b0;
      ce          = 1'b1;
      reset_i     = 1'b1;
      tick        = 0;
      num_errors  = 0;
      checks_done = 0;
      wait_clk(8);
      reset_i <= 1'b0;
      t_regs();
      t_pre();
      t_per();
      t_idle();
      t_ext();
      t_async();
      t_gate();
      t_ce();
      close_out();
   end
endmodule // tmr16_core_bench

bind tmr16_core tmr16_core_asserts tmr16_core_asserts_inst (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
